// ### src/dpid_pkg.sv
// package for the dual port interleave doubler block
// assumes one 100 MHz system clock; the converter clock arrives as a pin
package dpid_pkg;
	// ------------------------------------------------------------
	// widths and codes
	// ------------------------------------------------------------
	localparam int DATA_W = 14; // width of each input port
	localparam logic [13:0] FULL_SCALE = 14'h3fff; // maximum code, 16383
	localparam logic [13:0] CODE_RESET = 14'h0000; // output latch after reset
	localparam logic [1:0] MODE_IL2X = 2'h0; // interleaved, external 2x clock
	localparam logic [1:0] MODE_PORT1 = 2'h1; // port 1 only
	localparam logic [1:0] MODE_PORT2 = 2'h2; // port 2 only
	localparam logic [1:0] MODE_DOUBLER = 2'h3; // interleaved, doubler active
	localparam logic [1:0] PHASE_RESET = 2'h0; // phase counter reset value

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [13:0] port1; // first port word
		logic [13:0] port2; // second port word
	} dpid_pair_type;

	typedef struct packed {
		logic [13:0] true_output; // straight binary code
		logic [13:0] complement_output; // full scale minus code
	} dpid_out_type;
endpackage : dpid_pkg

// ### src/dpid_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes the pins are asynchronous to i_clk
`timescale 1ns/10ps
`default_nettype none
module dpid_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	// ------------------------------------------------------------
	// stages
	// ------------------------------------------------------------
	logic [WIDTH-1:0] meta_q; // first stage, read only by second
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q; // second stage
	logic [WIDTH-1:0] sync_d;

	// next values, zero during reset
	always_comb begin
		meta_d = i_resetn ? i_async : '0;
		sync_d = i_resetn ? meta_q : '0;
	end

	// register only
	always_ff @(posedge i_clk) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign o_sync = sync_q;
endmodule : dpid_sync
`default_nettype wire

// ### src/dpid_core.sv
// dual port interleave with internal clock doubler, device side
// assumes i_clk far faster than the converter clock pin; all pins async
// What this block does
// - doubler makes 2x update from 1x clock
// - two 14-bit ports, one differential clock
// - straight binary; all ones is full scale
// - output latch updates twice per clock
// - complement equals 16383 minus code
// - rising edge: latch ports, output gets port2
// - half period later output gets port1
// - both select pins high picks doubler interleave
// - grounded pll supply means mode pins rule
`timescale 1ns/10ps
`default_nettype none
module dpid_core #(
	parameter int DATA_W = dpid_pkg::DATA_W
) (
	input wire logic i_clk, // 100 MHz system clock
	input wire logic i_resetn, // synchronous, active low
	input wire logic i_conv_clk_p, // converter clock, true leg
	input wire logic i_conv_clk_n, // converter clock, inverted leg
	input wire logic [DATA_W-1:0] i_port1, // first port, data_bit_lsb at bit 0
	input wire logic [DATA_W-1:0] i_port2, // second port
	input wire logic i_mode_select_lo, // mode pin, low bit
	input wire logic i_mode_select_hi, // mode pin, high bit
	input wire logic i_pll_supply_pin, // high when pll powered
	output logic o_doubler_mode, // doubler interleave in force
	output logic o_update, // one-cycle pulse per output update
	output logic [DATA_W-1:0] o_true_output, // true path code
	output logic [DATA_W-1:0] o_complement_output // complement path code
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	localparam int PIN_W = 2 * DATA_W + 5;
	logic [PIN_W-1:0] pins_sync; // synchronised pin bundle
	logic clk_p_s; // synchronised clock legs
	logic clk_n_s;
	logic [DATA_W-1:0] p1_s; // synchronised port words
	logic [DATA_W-1:0] p2_s;
	logic sel_lo_s;
	logic sel_hi_s;
	logic pll_on_s;

	// every pin passes two flops before use
	dpid_sync #(
		.WIDTH(PIN_W)
	) u_sync (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_async({i_conv_clk_p, i_conv_clk_n, i_port1, i_port2,
			i_mode_select_lo, i_mode_select_hi, i_pll_supply_pin}),
		.o_sync(pins_sync)
	);

	assign {clk_p_s, clk_n_s, p1_s, p2_s, sel_lo_s, sel_hi_s, pll_on_s} = pins_sync;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// complement path: full scale minus code
	function automatic logic [DATA_W-1:0] complement_of(input logic [DATA_W-1:0] code);
		complement_of = dpid_pkg::FULL_SCALE - code;
	endfunction : complement_of

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	logic doubler_sel; // doubler interleave chosen
	always_comb begin
		// pll supply grounded: select pins pick the mux mode
		doubler_sel = !pll_on_s
			&& ({sel_hi_s, sel_lo_s} == dpid_pkg::MODE_DOUBLER);
	end

	// ------------------------------------------------------------
	// clock doubler: edges and half-period timing
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, // waiting for first rising edge
		ST_HIGH = 2'b01, // clock high phase
		ST_LOW = 2'b11 // clock low phase
	} dpid_state_type;

	dpid_state_type state_q;
	dpid_state_type state_d;
	logic clk_lvl_q; // last differential level
	logic clk_lvl_d;
	logic [15:0] period_q; // measured system cycles per clock period
	logic [15:0] period_d;
	logic [15:0] count_q; // cycles since last rising edge
	logic [15:0] count_d;
	logic clk_lvl; // differential decode of the legs
	logic rise; // rising edge of converter clock
	logic mid; // half-period point

	// the doubler uses a measured period, so no duty cycle is assumed of the source
	always_comb begin
		clk_lvl = clk_p_s & ~clk_n_s;
		rise = clk_lvl & ~clk_lvl_q;
		clk_lvl_d = clk_lvl;
		state_d = state_q;
		period_d = period_q;
		count_d = (count_q == 16'hffff) ? count_q : count_q + 16'h0001;
		mid = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (rise) begin
					state_d = ST_HIGH;
					count_d = 16'h0001;
				end
			end
			ST_HIGH, ST_LOW: begin
				if (!clk_lvl) begin
					state_d = ST_LOW;
				end
				// doubled edge at half the measured period
				if (count_q == {1'b0, period_q[15:1]} && period_q != 16'h0000) begin
					mid = 1'b1;
				end
				if (rise) begin
					state_d = ST_HIGH;
					period_d = count_q;
					count_d = 16'h0001;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// register only
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state_q <= ST_IDLE;
			clk_lvl_q <= 1'b0;
			period_q <= 16'h0000;
			count_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			clk_lvl_q <= clk_lvl_d;
			period_q <= period_d;
			count_q <= count_d;
		end
	end

	// ------------------------------------------------------------
	// input latches and output latch
	// ------------------------------------------------------------
	dpid_pkg::dpid_pair_type in_q; // port latches
	dpid_pkg::dpid_pair_type in_d;
	dpid_pkg::dpid_out_type out_q; // output latch, both paths
	dpid_pkg::dpid_out_type out_d;
	logic upd_q; // update pulse
	logic upd_d;

	// next values: rising edge takes port 2, mid edge port 1, else hold
	always_comb begin
		in_d = in_q;
		out_d = out_q; // hold between updates
		upd_d = 1'b0;
		if (doubler_sel && rise) begin
			in_d.port1 = p1_s;
			in_d.port2 = p2_s;
			out_d.true_output = in_q.port2; // previous port 2 word
			out_d.complement_output = complement_of(in_q.port2);
			upd_d = 1'b1;
		end else if (doubler_sel && mid) begin
			// only one port per update, rise has priority
			out_d.true_output = in_q.port1;
			out_d.complement_output = complement_of(in_q.port1);
			upd_d = 1'b1;
		end
	end

	// register only
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			in_q <= '0;
			out_q <= {dpid_pkg::CODE_RESET, dpid_pkg::FULL_SCALE};
			upd_q <= 1'b0;
		end else begin
			in_q <= in_d;
			out_q <= out_d;
			upd_q <= upd_d;
		end
	end

	assign o_true_output = out_q.true_output;
	assign o_complement_output = out_q.complement_output;
	assign o_update = upd_q;
	assign o_doubler_mode = doubler_sel;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_comp_sum: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_true_output + o_complement_output == dpid_pkg::FULL_SCALE)
		else $error("complement path does not sum to full scale");
	a_rise_port2: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(doubler_sel && rise) |=> (o_true_output == $past(in_q.port2) && o_update))
		else $error("rising edge did not load port 2 word");
	a_mid_port1: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(doubler_sel && mid && !rise) |=> (o_true_output == $past(in_q.port1)))
		else $error("mid point did not load port 1 word");
	a_latch_ports: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(doubler_sel && rise) |=> (in_q.port1 == $past(p1_s) && in_q.port2 == $past(p2_s)))
		else $error("port latches not captured on rising edge");
	a_hold_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!upd_d |=> $stable(o_true_output))
		else $error("output latch changed without update");
	a_mode_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!doubler_sel |=> !o_update)
		else $error("update outside doubler mode");
	a_pll_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
		pll_on_s |-> !o_doubler_mode)
		else $error("doubler mode with pll supplied");
	// count_q at a rise is the period the mid point will use next, so judge that one
	a_two_upd: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(doubler_sel && rise && state_q != ST_IDLE && count_q > 16'h0004
		&& count_q < 16'h0100)
		|=> o_update ##1 !o_update ##[1:200] o_update)
		else $error("no second update within the period");
endmodule : dpid_core
`default_nettype wire

// ### testbench/dpid_source.sv
// partner model: the logic that feeds both ports and the converter clock
// assumes the core takes every pin as asynchronous to its own clock
`timescale 1ns/10ps
`default_nettype none
module dpid_source #(
	parameter int HALF_NS = 40 // half period in ns, even duty
) (
	input wire logic i_run, // converter clock runs only while high
	input wire logic i_full, // ports carry full scale and zero
	output logic o_clk_p, // converter clock, true leg
	output logic o_clk_n, // converter clock, inverted leg
	output logic [13:0] o_port1, // first port word
	output logic [13:0] o_port2 // second port word
);
	// ------------------------------------------------------------
	// clock and data
	// ------------------------------------------------------------
	logic [7:0] k; // word index, tagged into the port words
	assign o_clk_n = ~o_clk_p; // one clock as a differential pair
	// equal high and low halves; stands low between bursts
	// words change on the fall, so the capturing rise sees them settled
	initial begin
		o_clk_p = 1'b0;
		k = 8'h00;
		o_port1 = 14'h1000;
		o_port2 = 14'h2000;
		forever begin
			wait (i_run);
			#HALF_NS o_clk_p = 1'b1;
			#HALF_NS o_clk_p = 1'b0;
			k = k + 8'h01;
			o_port1 = i_full ? 14'h3fff : {6'h10, k};
			o_port2 = i_full ? 14'h0000 : {6'h20, k};
		end
	end
endmodule : dpid_source
`default_nettype wire

// ### testbench/dual_port_interleave_doubler_bench.sv
// bench: source model drives the core; updates are logged and judged
// assumes 100 MHz i_clk and a converter clock of 8 i_clk cycles
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin errors++; \
	$display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module dual_port_interleave_doubler_bench;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic i_clk = 1'b0, i_resetn = 1'b0, lo = 1'b0, hi = 1'b0, pll = 1'b1;
	logic run = 1'b0, full = 1'b0, cp, cn, dbl, upd;
	logic [13:0] p1, p2, tru, cmp, held;
	logic [13:0] q[$]; // true codes seen at each update
	int errors = 0, n_tests = 0, i;
	always #5 i_clk = ~i_clk;
	dpid_source u_src (.i_run(run), .i_full(full), .o_clk_p(cp), .o_clk_n(cn),
		.o_port1(p1), .o_port2(p2));
	dpid_core u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_conv_clk_p(cp),
		.i_conv_clk_n(cn), .i_port1(p1), .i_port2(p2), .i_mode_select_lo(lo),
		.i_mode_select_hi(hi), .i_pll_supply_pin(pll), .o_doubler_mode(dbl),
		.o_update(upd), .o_true_output(tru), .o_complement_output(cmp));
	// log every update; complement judged on each one
	always @(posedge i_clk) begin
		if (upd === 1'b1) begin
			q.push_back(tru);
			`CHK("complement", dpid_pkg::FULL_SCALE - tru, cmp)
		end
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic set_mode(input logic [2:0] m); // {pll, hi, lo}
		@(posedge i_clk);
		#1 {pll, hi, lo} = m;
		repeat (4) @(posedge i_clk);
	endtask : set_mode
	task automatic burst(input int cyc); // run the converter clock a while
		q.delete();
		run = 1'b1;
		repeat (cyc - 1) @(posedge i_clk);
		#1 run = 1'b0; // drops before the last fall, so no extra period starts
		repeat (21) @(posedge i_clk);
	endtask : burst
	task automatic t_reset();
		`CHK("reset code", 14'h0000, tru)
		`CHK("reset comp", 14'h3fff, cmp)
		`CHK("reset pulse", 1'b0, upd)
	endtask : t_reset
	task automatic t_modes(); // only pll off with both selects high
		for (int m = 0; m < 8; m++) begin
			set_mode(m[2:0]);
			`CHK("doubler mode", (m == 3), dbl)
		end
	endtask : t_modes
	task automatic t_refuse(); // single port, then pll powered
		set_mode(3'h1);
		burst(80);
		`CHK("updates port mode", 0, q.size())
		set_mode(3'h7);
		burst(80);
		`CHK("updates pll on", 0, q.size())
	endtask : t_refuse
	task automatic t_stream(); // 20 clock periods in doubler mode
		logic [13:0] ex;
		set_mode(3'h3);
		burst(160);
		`CHK("two per period", 1'b1, q.size() >= 37 && q.size() <= 40)
		for (i = 2; i + 1 < q.size(); i++) begin
			ex = (q[i][13:12] == 2'h1) ? {2'h2, q[i][11:0]} : q[i] - 14'h0fff;
			`CHK("interleave order", ex, q[i + 1])
		end
		held = tru;
		repeat (30) @(posedge i_clk);
		`CHK("idle hold", held, tru)
	endtask : t_stream
	task automatic t_full(); // all ones on port1, zero on port2
		full = 1'b1;
		burst(64);
		full = 1'b0;
		`CHK("full scale seen", 1'b1, 14'h3fff inside {q})
		`CHK("zero seen", 1'b1, 14'h0000 inside {q})
	endtask : t_full
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge i_clk);
		#1 i_resetn = 1'b1;
		repeat (4) @(posedge i_clk);
		t_reset();
		t_modes();
		t_refuse();
		t_stream();
		t_full();
		tally_and_finish();
	end
	initial begin
		#100000;
		errors++;
		tally_and_finish();
	end
endmodule : dual_port_interleave_doubler_bench
`default_nettype wire
